// ---- shared/pwm_duty_cfg.svh ----
// Constants for the 8-bit PWM duty-setting part
//
// Contract
// (RULE1) Each channel compares duty against 8-bit counter
// (RULE2) Duty above count drives high, below drives low
// (RULE3) High fraction is (x + 0.25) over 256
// (RULE4) Quarter-count high pulse even at duty zero
// (RULE5) Software loads duty via buffer, then transfer
// (RULE6) All channels share clock, width and period
// (RULE7) Basic clock is 1.125 or 0.1125 MHz
// (RULE8) Periods give nominal 4.4 kHz or 440 Hz
// (RULE9) Duty channel 2 doubles as timer 3 modulus
// (RULE10) In timer 3, channels 1/0 stay plain latches
// (RULE11) Timer 3 forces all pins to port mode
// (RULE12) Counter wraps from maximum to zero, no gap
`ifndef PWM_DUTY_CFG_SVH
`define PWM_DUTY_CFG_SVH

// Counter and data widths
`define PWM_CNT_W 8
`define PWM_CNT_MAX 8'hFF
`define PWM_CNT_ZERO 8'h00
`define PWM_CH_N 3

// Reset values
`define DUTY_RST 8'h00
`define PIN_LVL_RST 1'b1

// Timing: system clock and the two basic-clock rates, in Hz
`define SYS_CLK_HZ 26'd25000000
`define BASIC_FAST_HZ 26'd1125000
`define BASIC_SLOW_HZ 26'd112500
// System cycles forming a quarter of one basic count, rounded down
`define QTR_FAST_CYC (`SYS_CLK_HZ / (26'd4 * `BASIC_FAST_HZ))
`define QTR_SLOW_CYC (`SYS_CLK_HZ / (26'd4 * `BASIC_SLOW_HZ))

`endif

// ---- shared/pwm_duty_pkg.sv ----
// Types shared by the PWM duty-setting design
package pwm_duty_pkg;

   // Channel selector for transfer and readback
   typedef enum logic [1:0] {
      SEL_CH0 = 2'h0,
      SEL_CH1 = 2'h1,
      SEL_CH2 = 2'h2,
      SEL_NONE = 2'h3
   } ch_sel_e;

   // One request from the processor side
   typedef struct packed {
      logic put;
      logic get;
      ch_sel_e sel;
   } xfer_req_s;

   // Open-drain pin group: o is the driven level, oe enables it
   typedef struct packed {
      logic [2:0] o;
      logic [2:0] oe;
   } od_pins_s;

   typedef logic [7:0] duty_t;

endpackage

// ---- design/pwm_basic_clock.sv ----
// Basic-clock enable generator with quarter-count phase
`timescale 1ns/100ps
`default_nettype none
`include "pwm_duty_cfg.svh"

module pwm_basic_clock (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Control
   input wire logic slow_sel,
   input wire logic run,
   // Timing outputs
   output logic tick,
   output logic qtr
);

   logic [25:0] acc_q, acc_d;
   logic [25:0] inc;
   logic [25:0] sum;
   logic [7:0] sub_q, sub_d;
   logic [25:0] qlim;
   logic tick_q, tick_d;

   // Fractional accumulator keeps the exact average rate
   always_comb begin
      inc = slow_sel ? `BASIC_SLOW_HZ : `BASIC_FAST_HZ; // see (RULE7)
      qlim = slow_sel ? `QTR_SLOW_CYC : `QTR_FAST_CYC;
      sum = acc_q + inc;
      acc_d = acc_q;
      tick_d = 1'b0;
      sub_d = sub_q;
      if (!run) begin
         acc_d = 26'h0;
         sub_d = 8'h00;
      end else begin
         if (sum >= `SYS_CLK_HZ) begin
            acc_d = sum - `SYS_CLK_HZ;
            tick_d = 1'b1;
         end else begin
            acc_d = sum;
         end
         // Sub-count restarts with each basic count; saturates
         if (tick_q) begin
            sub_d = 8'h01;
         end else if (sub_q != 8'hFF) begin
            sub_d = sub_q + 8'h01;
         end
      end
   end

   // State registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         acc_q <= 26'h0;
         sub_q <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         sub_q <= sub_d;
         tick_q <= tick_d;
      end
   end

   // Count advances on tick_q
   assign tick = tick_q;
   // Quarter phase covers the first qlim cycles of each basic count, so
   // the extension joins the count's start and never splits the pulse
   assign qtr = ({18'h0, sub_q} <= qlim); // see (RULE4)

endmodule
`default_nettype wire

// ---- design/pwm_duty_setting.sv ----
// Three-channel 8-bit PWM duty-setting unit with open-drain pins
`timescale 1ns/100ps
`default_nettype none
`include "pwm_duty_cfg.svh"

module pwm_duty_setting
   import pwm_duty_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Shared mode controls
   input wire logic tm3_mode,
   input wire logic cnt9_sel,
   input wire logic slow_sel,
   // Pin function selects, 1 = PWM output
   input wire logic pin2_func_sel,
   input wire logic pin1_func_sel,
   input wire logic pin0_func_sel,
   // General-purpose port levels for the three pins
   input wire logic [2:0] port_level,
   // Data transfer from the processor
   input wire logic [7:0] transfer_buffer,
   input wire xfer_req_s req,
   // Readback and timer 3 modulus
   output logic [7:0] get_data,
   output logic get_valid,
   output logic [7:0] tm3_modulus,
   // Open-drain pins
   input wire logic [2:0] pin_i,
   output od_pins_s pins
);

   // Timing from the shared basic clock
   logic tick;
   logic qtr;
   logic run;
   logic [2:0] func_sel;
   // Counter and duty storage
   logic [7:0] count_q, count_d;
   duty_t duty_q [`PWM_CH_N];
   duty_t duty_d [`PWM_CH_N];
   logic [2:0] put_hit;
   // Pin, readback and modulus registers
   logic [2:0] pwm_hi;
   logic [2:0] lvl_d;
   logic [2:0] oe_q, oe_d;
   logic [2:0] get_hit;
   logic [7:0] get_q, get_d;
   logic get_v_q, get_v_d;
   logic [7:0] mod_q, mod_d;

   // Duty compare with quarter-count extension
   function automatic logic duty_high(input duty_t x,
                                      input logic [7:0] c,
                                      input logic q);
      duty_high = (x > c) || ((x == c) && q);
   endfunction

   // One-hot decode of a channel select, shared by put and get paths;
   // the none code hits no channel
   function automatic logic [2:0] sel_decode(input ch_sel_e s);
      unique case (s)
         SEL_CH0: sel_decode = 3'h1;
         SEL_CH1: sel_decode = 3'h2;
         SEL_CH2: sel_decode = 3'h4;
         SEL_NONE: sel_decode = 3'h0;
      endcase
   endfunction

   assign func_sel = {pin2_func_sel, pin1_func_sel, pin0_func_sel};
   // Counter runs only in 8-bit PWM mode; other modes live elsewhere
   assign run = !tm3_mode && !cnt9_sel;

   // One shared basic clock for every channel
   pwm_basic_clock u_basic (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .slow_sel(slow_sel),
      .run(run),
      .tick(tick),
      .qtr(qtr)
   ); // see (RULE6)

   // Shared 8-bit counter, 256 counts per period
   always_comb begin
      count_d = count_q;
      if (!run) begin
         count_d = `PWM_CNT_ZERO;
      end else if (tick) begin
         if (count_q == `PWM_CNT_MAX) begin
            count_d = `PWM_CNT_ZERO; // see (RULE12)
         end else begin
            count_d = count_q + 8'h01; // see (RULE3) (RULE8)
         end
      end
   end

   // Counter register; reset starts a fresh period at count zero
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         count_q <= `PWM_CNT_ZERO;
      end else begin
         count_q <= count_d;
      end
   end

   // Duty registers loaded from the transfer buffer; a put with the
   // none code hits no channel, so a stray select is harmless
   always_comb begin
      put_hit = req.put ? sel_decode(req.sel) : 3'h0; // see (RULE5)
      for (int i = 0; i < `PWM_CH_N; i++) begin
         duty_d[i] = duty_q[i];
      end
      // Transfer writes storage in every mode, so in timer 3 mode
      // channels 1 and 0 remain plain latches
      if (put_hit[0]) begin
         duty_d[0] = transfer_buffer; // see (RULE10)
      end
      if (put_hit[1]) begin
         duty_d[1] = transfer_buffer; // see (RULE10)
      end
      // Channel 2 storage doubles as the timer 3 modulus
      if (put_hit[2]) begin
         duty_d[2] = transfer_buffer; // see (RULE9)
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `PWM_CH_N; i++) begin
            duty_q[i] <= `DUTY_RST;
         end
      end else begin
         for (int i = 0; i < `PWM_CH_N; i++) begin
            duty_q[i] <= duty_d[i];
         end
      end
   end

   // Per-channel compare and pin level selection
   genvar g;
   generate
      for (g = 0; g < `PWM_CH_N; g++) begin : g_ch
         // Low outside the 8-bit run mode
         assign pwm_hi[g] = run &&
            duty_high(duty_q[g], count_q, qtr); // see (RULE1) (RULE2) (RULE4)
         // Timer 3 overrides each pin select to port mode
         assign lvl_d[g] = (func_sel[g] && !tm3_mode) ? pwm_hi[g] :
            port_level[g]; // see (RULE11)
      end
   endgenerate

   // Enable is the inverse of the wanted level, taken before the
   // register so the pin comes straight from a flop with no gate after
   always_comb begin
      oe_d = ~lvl_d;
   end

   // Pins register one cycle after the compare; reset releases them
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         oe_q <= ~{3{`PIN_LVL_RST}};
      end else begin
         oe_q <= oe_d;
      end
   end

   // Readback of stored duty; data holds between gets so software may
   // read it at leisure, while the valid flag is a one-cycle pulse
   always_comb begin
      get_hit = req.get ? sel_decode(req.sel) : 3'h0;
      get_d = get_q;
      get_v_d = 1'b0;
      if (req.get) begin
         get_v_d = 1'b1;
         get_d = 8'h00;
         for (int i = 0; i < `PWM_CH_N; i++) begin
            if (get_hit[i]) begin
               get_d = duty_q[i];
            end
         end
      end
   end

   // Readback registers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         get_q <= 8'h00;
         get_v_q <= 1'b0;
      end else begin
         get_q <= get_d;
         get_v_q <= get_v_d;
      end
   end

   // Timer 3 modulus mirrors channel 2 storage with one cycle of lag;
   // no second copy of the byte exists, so the two uses exclude
   always_comb begin
      mod_d = duty_q[2]; // see (RULE9)
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mod_q <= `DUTY_RST;
      end else begin
         mod_q <= mod_d;
      end
   end

   // Open drain: pull low only, a high level is left to the pull-up
   assign pins.o = 3'h0;
   assign pins.oe = oe_q;
   assign get_data = get_q;
   assign get_valid = get_v_q;
   assign tm3_modulus = mod_q;

endmodule
`default_nettype wire

// ---- testbench/pwm_pin_pullup.sv ----
// Pull-up network of the three open-drain pins
`timescale 1ns/100ps
`default_nettype none
module pwm_pin_pullup
   import pwm_duty_pkg::*;
(
   // From the unit
   input wire od_pins_s pins,
   // Wire levels
   output logic [2:0] lvl
);
   // A released pin floats up, never a stale level
   assign lvl = (pins.o & pins.oe) | ~pins.oe;
endmodule
`default_nettype wire

// ---- testbench/pwm_duty_monitor.sv ----
// Port checker of the PWM duty unit
`timescale 1ns/100ps
`default_nettype none
module pwm_duty_monitor
   import pwm_duty_pkg::*;
(
   // Clock, reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Inputs
   input wire logic tm3_mode,
   input wire logic cnt9_sel,
   input wire logic pin0_func_sel,
   input wire logic [2:0] port_level,
   input wire logic [7:0] transfer_buffer,
   input wire xfer_req_s req,
   // Outputs
   input wire logic [7:0] get_data,
   input wire logic get_valid,
   input wire logic [7:0] tm3_modulus,
   input wire od_pins_s pins
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Pins only ever pull low
   a_pin_od: assert property (pins.o == 3'h0)
      else $error("pin driven");
   // Readback answers once, a cycle later, then holds
   a_get_ack: assert property (req.get |=> get_valid)
      else $error("no ack");
   a_ack_cause: assert property (get_valid |-> $past(req.get))
      else $error("stray ack");
   a_get_hold: assert property (!req.get |=> $stable(get_data))
      else $error("data moved");
   a_none_zero: assert property (req.get && req.sel == SEL_NONE
      |=> get_data == 8'h00) else $error("none read");
   // Channel 2 storage is the modulus, one cycle behind
   a_mod_copy: assert property (req.put && req.sel == SEL_CH2
      |=> ##1 tm3_modulus == $past(transfer_buffer, 2)) else $error("mod");
   // Timer use hands every pin to the port level
   a_tm3_port: assert property ((tm3_mode && $stable(port_level))[*3]
      |-> pins.oe == ~port_level) else $error("port");
   // Other widths stop this counter, level low
   a_cnt9_low: assert property ((cnt9_sel && !tm3_mode && pin0_func_sel)[*3]
      |-> pins.oe[0]) else $error("cnt9");
   cover property (get_valid);
   cover property ($fell(pins.oe[0]) && !tm3_mode);
   cover property (tm3_mode && pins.oe != 3'h0);
endmodule
bind pwm_duty_setting pwm_duty_monitor mon_u (.clk_sys, .rstn, .tm3_mode,
   .cnt9_sel, .pin0_func_sel, .port_level, .transfer_buffer, .req,
   .get_data, .get_valid, .tm3_modulus, .pins);
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench of the PWM duty unit
`timescale 1ns/100ps
`default_nettype none
`include "pwm_duty_cfg.svh"
module tb_top;
   import pwm_duty_pkg::*;
   logic clk_sys = 0, rstn = 0, tm3_mode = 0, cnt9_sel = 0, slow_sel = 0;
   logic pin2_func_sel = 0, pin1_func_sel = 0, pin0_func_sel = 0;
   logic [2:0] port_level = 3'h0, pin_i;
   logic [7:0] transfer_buffer = 8'h00, get_data, tm3_modulus;
   logic get_valid;
   xfer_req_s req = '0;
   od_pins_s pins;
   duty_t mdl [4] = '{default: 8'h00};
   duty_t expq [$];
   integer num_errors = 0, comparisons = 0, seed = 98, t, r, s, hi [3];
   real c;
   pwm_duty_setting dut_u (.clk_sys, .rstn, .tm3_mode, .cnt9_sel, .slow_sel,
      .pin2_func_sel, .pin1_func_sel, .pin0_func_sel, .port_level,
      .transfer_buffer, .req, .get_data, .get_valid, .tm3_modulus, .pin_i,
      .pins);
   pwm_pin_pullup pull_u (.pins, .lvl(pin_i));
   // 25 MHz clock
   always #20 clk_sys = ~clk_sys;
   task check(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
         num_errors++;
      end
   endtask
   // One put or get; a get notes its expected byte
   task xfer(input logic p, input logic [1:0] sl, input duty_t d);
      @(negedge clk_sys);
      req = '{p, !p, ch_sel_e'(sl)};
      transfer_buffer = d;
      if (p && sl != 2'h3) mdl[sl] = d;
      if (!p) expq.push_back(mdl[sl]);
      @(negedge clk_sys);
      req = '0;
   endtask
   // Any full period, fall to fall of pin 0, holds each pulse once
   task measure(input logic sl);
      logic p;
      integer n;
      real e;
      n = 0;
      p = 0;
      c = 25.0e6 / (sl ? 112.5e3 : 1.125e6);
      hi = '{0, 0, 0};
      @(negedge pin_i[0]);
      forever begin
         @(negedge clk_sys);
         if (!pin_i[0] && p) break;
         p = pin_i[0];
         for (r = 0; r < 3; r++) hi[r] += pin_i[r];
         n++;
      end
      check("period", n > 256 * c - 2.5 && n < 256 * c + 2.5, 1);
      for (r = 0; r < 3; r++) begin
         e = mdl[r] * c + (sl ? `QTR_SLOW_CYC : `QTR_FAST_CYC);
         check("high", hi[r] > e - 2.5 && hi[r] < e + 2.5, 1);
      end
   endtask
   task print_verdict;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Readback results against the oldest note
   always @(negedge clk_sys)
      if (get_valid === 1'b1) check("get", get_data, expq.pop_front());
   // Tests need some 63k cycles; cut off at 90k
   initial begin
      #3600000;
      num_errors++;
      print_verdict();
   end
   initial begin
      repeat (20) @(negedge clk_sys);
      rstn = 1;
      for (t = 0; t < 10; t++) begin
         r = $random(seed);
         xfer(1, r[1:0], r[15:8]);
         xfer(0, r[5:4], 8'h00);
      end
      tm3_mode = 1;
      for (t = 0; t < 3; t++) xfer(1, t[1:0], 8'h5A + t[7:0]);
      @(negedge clk_sys);
      check("modulus", tm3_modulus, 8'h5C);
      xfer(0, 0, 0);
      xfer(0, 1, 0);
      for (t = 0; t < 16; t++) begin
         tm3_mode = t[3];
         {pin2_func_sel, pin1_func_sel, pin0_func_sel} = {3{t[3]}};
         port_level = t[2:0];
         repeat (4) @(negedge clk_sys);
         check("port", pin_i, t[2:0]);
      end
      tm3_mode = 0;
      cnt9_sel = 1;
      repeat (3) @(negedge clk_sys);
      check("cnt9", pin_i, 3'h0);
      cnt9_sel = 0;
      // Reset restarts the count; duties 0, 80h, FFh at both rates
      for (s = 0; s < 2; s++) begin
         rstn = 0;
         @(negedge clk_sys);
         rstn = 1;
         slow_sel = s[0];
         for (t = 0; t < 3; t++) xfer(1, t[1:0], t[1] ? 8'hFF : {t[0], 7'h00});
         measure(s[0]);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
